/* src/rcpe_pkg.sv */
// constants, property map layout and carrier types of the command and property engine
package rcpe_pkg;

  // command opcodes
  localparam logic [7:0] CMD_POWER_UP = 8'h01;
  localparam logic [7:0] CMD_REV_QUERY = 8'h10;
  localparam logic [7:0] CMD_POWER_DOWN = 8'h11;
  localparam logic [7:0] CMD_PROP_WRITE = 8'h12;
  localparam logic [7:0] CMD_PROP_READ = 8'h13;
  localparam logic [7:0] CMD_IRQ_STATUS = 8'h14;
  localparam logic [7:0] CMD_FIX_ARGS = 8'h15;
  localparam logic [7:0] CMD_FIX_DATA = 8'h16;
  localparam logic [7:0] CMD_RX_FREQ = 8'h20;
  localparam logic [7:0] CMD_RX_SEARCH = 8'h21;
  localparam logic [7:0] CMD_RX_TUNE_RPT = 8'h22;
  localparam logic [7:0] CMD_RX_QUAL_RPT = 8'h23;
  localparam logic [7:0] CMD_RX_DATA_RPT = 8'h24;
  localparam logic [7:0] CMD_RX_GAIN_RPT = 8'h27;
  localparam logic [7:0] CMD_RX_GAIN_FORCE = 8'h28;
  localparam logic [7:0] CMD_TX_FREQ = 8'h30;
  localparam logic [7:0] CMD_TX_POWER = 8'h31;
  localparam logic [7:0] CMD_TX_MEASURE = 8'h32;
  localparam logic [7:0] CMD_TX_TUNE_RPT = 8'h33;
  localparam logic [7:0] CMD_TX_AUDIO_RPT = 8'h34;
  localparam logic [7:0] CMD_TX_GROUP_BUF = 8'h35;
  localparam logic [7:0] CMD_TX_NAME = 8'h36;
  localparam logic [7:0] CMD_PIN_DRIVE_SEL = 8'h80;
  localparam logic [7:0] CMD_PIN_LEVEL = 8'h81;

  // power-up argument: function select and interrupt-pin enable
  localparam logic [3:0] FUNC_RX = 4'h0;
  localparam logic [3:0] FUNC_TX = 4'h2;
  localparam int PWR_IRQ_EN_BIT = 6;
  localparam int ACK_BIT = 0;
  // pin fields in the pin commands: bit 1 is pin one
  localparam int PIN_LSB = 1;

  // status byte positions
  localparam int ST_CTS = 7;
  localparam int ST_ERR = 6;
  localparam int ST_RSQ = 3;
  localparam int ST_RDS = 2;
  localparam int ST_ASQ = 1;
  localparam int ST_STC = 0;

  // transfer sizes
  localparam int CMD_BYTES = 8;
  localparam int RSP_BYTES = 16;

  // command execution time
  localparam int CLK_HZ = 10_000_000;
  localparam int EXEC_NS = 2500;
  localparam int EXEC_CYC = (EXEC_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // revision answer, values arbitrary
  localparam logic [7:0] REV_PART = 8'h5A;
  localparam logic [7:0] REV_MAJOR = 8'h31;
  localparam logic [7:0] REV_MINOR = 8'h30;

  // reference clock property range
  localparam logic [15:0] REFCLK_MIN = 16'h799A;
  localparam logic [15:0] REFCLK_MAX = 16'h8666;
  localparam int IDX_REFCLK = 5;

  localparam int PROP_N = 34;
  localparam logic [15:0] PROP_ID [PROP_N] = '{
    16'h0001, 16'h0101, 16'h0102, 16'h0103, 16'h0104, 16'h0201, 16'h0202,
    16'h2100, 16'h2101, 16'h2102, 16'h2103, 16'h2104, 16'h2105, 16'h2106, 16'h2107,
    16'h2200, 16'h2201, 16'h2202, 16'h2203, 16'h2204, 16'h2205,
    16'h2300, 16'h2301, 16'h2302, 16'h2303, 16'h2304,
    16'h2C00, 16'h2C01, 16'h2C02, 16'h2C03, 16'h2C04, 16'h2C05, 16'h2C06, 16'h2C07};
  localparam logic [15:0] PROP_RST [PROP_N] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0001,
    16'h0003, 16'h1AA9, 16'h02A3, 16'h00C8, 16'h327C, 16'h0000, 16'h0000, 16'h4A38,
    16'h0002, 16'hFFD8, 16'h0000, 16'h0004, 16'h000F, 16'h0066,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h40A7, 16'h0003, 16'h1008, 16'h0003, 16'h0001, 16'hE0E0, 16'h0000};

  typedef enum logic {ST_IDLE, ST_EXEC} rcpe_fsm_t;

  // command handed to the signal processing behind the engine
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [CMD_BYTES-2:0][7:0] args;
  } rcpe_dsp_cmd_t;

  typedef struct packed {
    rcpe_fsm_t fsm;
    logic [15:0] timer;
    logic [3:0] nbytes;
    logic [CMD_BYTES-1:0][7:0] cmd;
    logic [RSP_BYTES-1:0][7:0] rsp;
    logic [3:0] rsp_idx;
    logic cts;
    logic err;
    logic stc;
    logic audio_signal_quality;
    logic rds;
    logic received_signal_quality;
    logic pwr;
    logic mode_tx;
    logic irq_en;
    logic [2:0] pin_oe;
    logic [2:0] pin_lvl;
    logic [PROP_N-1:0][15:0] props;
    logic [7:0] status;
    logic [7:0] rsp_byte;
    logic bus_en;
    logic afc_en;
    logic [2:0] pin_out;
    logic [2:0] pin_oe_n;
    logic rds_pop;
    rcpe_dsp_cmd_t dsp;
  } rcpe_state_t;

endpackage

/* src/rcpe_engine.sv */
// command interpreter, property map and general-purpose pins of the transceiver
`timescale 1ns/1ns

// Summary of operation
// - three output pins, each drives low, drives high or floats.
// - pin two may act as interrupt line for tune, quality and data events.
// - reset held disables processing, restores every property default, disables bus.
// - after reset release the device sits powered down.
// - powered down keeps processing off and answers every command except 0x01 with the error bit.
// - a command is one opcode byte followed by its argument bytes.
// - every command answers with at least a status byte with interrupt and ready.
// - 0x01 powers up with mode, 0x10 returns revision, 0x11 powers down.
// - 0x12 writes an addressed property, 0x13 reads it back.
// - 0x14 reports interrupt status bits.
// - 0x15 and 0x16 are reserved patch download commands.
// - transmit 0x30 tunes, 0x31 sets power, 0x32 measures noise.
// - 0x33 reports status of the last transmit tune command.
// - 0x34 audio report, 0x35 group buffer, 0x36 service name strings.
// - 0x80 selects drive or float per pin, 0x81 sets each pin level.
// - receive 0x20 tunes, 0x21 searches, 0x22 reports tune or search result.
// - receive 0x23 reports signal quality, 0x24 returns data and pops one entry.
// - receive 0x27 reports gain settings, 0x28 forces a fixed gain.
// - reference clock property accepts 31130 to 34406 or 0; default 32768.
// - deviation properties count 10 Hz steps; defaults 6825 and 675.
// - multiplex component enable defaults to 0x0003.
// - a command carries at most eight bytes, opcode plus seven arguments.
module rcpe_engine #(
  parameter int EXEC_CYCLES = rcpe_pkg::EXEC_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd_wr_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic cmd_go_i,
  input wire logic rsp_rd_i,
  input wire logic tune_done_i,
  input wire logic asq_evt_i,
  input wire logic rds_evt_i,
  input wire logic rsq_evt_i,
  output logic [7:0] status_o,
  output logic [7:0] rsp_byte_o,
  output logic bus_en_o,
  output logic powered_o,
  output logic mode_tx_o,
  output logic afc_en_o,
  output logic rds_pop_o,
  output rcpe_pkg::rcpe_dsp_cmd_t dsp_cmd_o,
  output logic [rcpe_pkg::PROP_N-1:0][15:0] prop_map_o,
  output logic general_output_one_o,
  output logic general_output_one_oe_n_o,
  output logic general_output_two_irq_o,
  output logic general_output_two_irq_oe_n_o,
  output logic general_output_three_bitclk_o,
  output logic general_output_three_bitclk_oe_n_o
);

  if (EXEC_CYCLES < 1 || EXEC_CYCLES > 65535) begin : g_chk
    $error("EXEC_CYCLES out of range");
  end

  localparam int EXEC_A = EXEC_CYCLES + 1;

  rcpe_pkg::rcpe_state_t s_q;
  rcpe_pkg::rcpe_state_t s_d;

  // property lookup: hit flag and index
  function automatic logic [6:0] prop_find(input logic [15:0] id);
    logic [6:0] r;
    r = '0;
    for (int i = 0; i < rcpe_pkg::PROP_N; i++) begin
      if (rcpe_pkg::PROP_ID[i] == id) begin
        r = {1'b1, 6'(i)};
      end
    end
    return r;
  endfunction

  function automatic rcpe_pkg::rcpe_state_t rst_state();
    rcpe_pkg::rcpe_state_t r;
    r = '0;
    r.fsm = rcpe_pkg::ST_IDLE;
    r.cts = 1'b1;
    r.pin_oe_n = 3'h7;
    r.status = 8'h80;
    r.rsp_byte = 8'h80;
    // control bus stays off while reset is held
    r.bus_en = 1'b0;
    r.afc_en = rcpe_pkg::PROP_RST[rcpe_pkg::IDX_REFCLK] != 16'h0000;
    for (int i = 0; i < rcpe_pkg::PROP_N; i++) begin
      r.props[i] = rcpe_pkg::PROP_RST[i];
    end
    return r;
  endfunction

  logic [7:0] op;
  logic [6:0] hit_idx;
  logic [15:0] pval;
  logic exec_done;
  logic irq_pend;
  assign op = s_q.cmd[0];
  assign hit_idx = prop_find({s_q.cmd[2], s_q.cmd[3]});
  assign pval = {s_q.cmd[4], s_q.cmd[5]};
  assign exec_done = (s_q.fsm == rcpe_pkg::ST_EXEC) && (s_q.timer == 16'h0000);

  always_comb begin
    s_d = s_q;
    s_d.dsp.valid = 1'b0;
    s_d.rds_pop = 1'b0;
    irq_pend = 1'b0;
    case (s_q.fsm)
      rcpe_pkg::ST_IDLE: begin
        // bytes beyond eight are dropped
        if (cmd_wr_i && s_q.cts && s_q.nbytes < 4'(rcpe_pkg::CMD_BYTES)) begin
          s_d.cmd[s_q.nbytes[2:0]] = cmd_byte_i;
          s_d.nbytes = s_q.nbytes + 4'h1;
        end
        if (cmd_go_i && s_q.cts && s_q.nbytes != 4'h0) begin
          s_d.cts = 1'b0;
          s_d.fsm = rcpe_pkg::ST_EXEC;
          s_d.timer = 16'(EXEC_CYCLES - 1);
        end
        if (rsp_rd_i && s_q.cts && s_q.rsp_idx != 4'hF) begin
          s_d.rsp_idx = s_q.rsp_idx + 4'h1;
        end
      end
      rcpe_pkg::ST_EXEC: begin
        if (s_q.timer != 16'h0000) begin
          s_d.timer = s_q.timer - 16'h0001;
        end else begin
          s_d.fsm = rcpe_pkg::ST_IDLE;
          s_d.cts = 1'b1;
          s_d.nbytes = 4'h0;
          s_d.rsp_idx = 4'h0;
          s_d.rsp = '0;
          s_d.err = 1'b0;
          s_d.dsp.opcode = op;
          s_d.dsp.args = s_q.cmd[rcpe_pkg::CMD_BYTES-1:1];
          if (!s_q.pwr && op != rcpe_pkg::CMD_POWER_UP) begin
            s_d.err = 1'b1;
          end else begin
            case (op)
              rcpe_pkg::CMD_POWER_UP: begin
                if (s_q.cmd[1][3:0] == rcpe_pkg::FUNC_RX
                    || s_q.cmd[1][3:0] == rcpe_pkg::FUNC_TX) begin
                  s_d.pwr = 1'b1;
                  s_d.mode_tx = (s_q.cmd[1][3:0] == rcpe_pkg::FUNC_TX);
                  s_d.irq_en = s_q.cmd[1][rcpe_pkg::PWR_IRQ_EN_BIT];
                end else begin
                  s_d.err = 1'b1;
                end
              end
              rcpe_pkg::CMD_REV_QUERY: begin
                s_d.rsp[1] = rcpe_pkg::REV_PART;
                s_d.rsp[2] = rcpe_pkg::REV_MAJOR;
                s_d.rsp[3] = rcpe_pkg::REV_MINOR;
              end
              rcpe_pkg::CMD_POWER_DOWN: begin
                s_d.pwr = 1'b0;
                s_d.irq_en = 1'b0;
              end
              rcpe_pkg::CMD_PROP_WRITE: begin
                if (!hit_idx[6]) begin
                  s_d.err = 1'b1;
                end else if (int'(hit_idx[5:0]) == rcpe_pkg::IDX_REFCLK && pval != 16'h0000
                    && (pval < rcpe_pkg::REFCLK_MIN || pval > rcpe_pkg::REFCLK_MAX)) begin
                  s_d.err = 1'b1;
                end else begin
                  s_d.props[hit_idx[5:0]] = pval;
                end
              end
              rcpe_pkg::CMD_PROP_READ: begin
                if (hit_idx[6]) begin
                  s_d.rsp[2] = s_q.props[hit_idx[5:0]][15:8];
                  s_d.rsp[3] = s_q.props[hit_idx[5:0]][7:0];
                end else begin
                  s_d.err = 1'b1;
                end
              end
              // status alone answers these
              rcpe_pkg::CMD_IRQ_STATUS, rcpe_pkg::CMD_FIX_ARGS, rcpe_pkg::CMD_FIX_DATA: begin
              end
              rcpe_pkg::CMD_PIN_DRIVE_SEL: begin
                s_d.pin_oe = s_q.cmd[1][rcpe_pkg::PIN_LSB +: 3];
              end
              rcpe_pkg::CMD_PIN_LEVEL: begin
                s_d.pin_lvl = s_q.cmd[1][rcpe_pkg::PIN_LSB +: 3];
              end
              rcpe_pkg::CMD_TX_FREQ, rcpe_pkg::CMD_TX_POWER, rcpe_pkg::CMD_TX_MEASURE,
              rcpe_pkg::CMD_TX_NAME, rcpe_pkg::CMD_TX_GROUP_BUF: begin
                s_d.err = !s_q.mode_tx;
                s_d.dsp.valid = s_q.mode_tx;
              end
              rcpe_pkg::CMD_TX_TUNE_RPT, rcpe_pkg::CMD_TX_AUDIO_RPT: begin
                s_d.err = !s_q.mode_tx;
                s_d.dsp.valid = s_q.mode_tx;
                if (s_q.mode_tx && s_q.cmd[1][rcpe_pkg::ACK_BIT]) begin
                  if (op == rcpe_pkg::CMD_TX_TUNE_RPT) begin
                    s_d.stc = 1'b0;
                  end else begin
                    s_d.audio_signal_quality = 1'b0;
                  end
                end
                s_d.rsp[1] = {7'h00, s_q.mode_tx && (op == rcpe_pkg::CMD_TX_TUNE_RPT
                    ? s_q.stc : s_q.audio_signal_quality)};
              end
              rcpe_pkg::CMD_RX_FREQ, rcpe_pkg::CMD_RX_SEARCH, rcpe_pkg::CMD_RX_GAIN_RPT,
              rcpe_pkg::CMD_RX_GAIN_FORCE: begin
                s_d.err = s_q.mode_tx;
                s_d.dsp.valid = !s_q.mode_tx;
              end
              rcpe_pkg::CMD_RX_TUNE_RPT, rcpe_pkg::CMD_RX_QUAL_RPT,
              rcpe_pkg::CMD_RX_DATA_RPT: begin
                s_d.err = s_q.mode_tx;
                s_d.dsp.valid = !s_q.mode_tx;
                if (!s_q.mode_tx && s_q.cmd[1][rcpe_pkg::ACK_BIT]) begin
                  if (op == rcpe_pkg::CMD_RX_TUNE_RPT) begin
                    s_d.stc = 1'b0;
                  end else if (op == rcpe_pkg::CMD_RX_QUAL_RPT) begin
                    s_d.received_signal_quality = 1'b0;
                  end else begin
                    s_d.rds = 1'b0;
                  end
                end
                s_d.rds_pop = !s_q.mode_tx && op == rcpe_pkg::CMD_RX_DATA_RPT;
              end
              default: begin
                s_d.err = 1'b1;
              end
            endcase
          end
        end
      end
      default: begin
        s_d.fsm = rcpe_pkg::ST_IDLE;
      end
    endcase
    // events are taken after acknowledges so a same-cycle event survives
    if (s_q.pwr) begin
      s_d.stc = s_d.stc | tune_done_i;
      s_d.audio_signal_quality = s_d.audio_signal_quality | (asq_evt_i & s_q.mode_tx);
      s_d.rds = s_d.rds | rds_evt_i;
      s_d.received_signal_quality = s_d.received_signal_quality | (rsq_evt_i & !s_q.mode_tx);
    end
    s_d.status = {s_d.cts, s_d.err, 2'b00, s_d.received_signal_quality, s_d.rds, s_d.audio_signal_quality, s_d.stc};
    s_d.rsp_byte = (s_d.rsp_idx == 4'h0) ? s_d.status : s_d.rsp[s_d.rsp_idx];
    irq_pend = |(s_d.status[3:0] & s_d.props[0][3:0]);
    // pin drivers; oe low means driving
    for (int i = 0; i < 3; i++) begin
      s_d.pin_out[i] = s_d.pin_lvl[i];
      s_d.pin_oe_n[i] = !s_d.pin_oe[i];
    end
    if (s_d.irq_en) begin
      s_d.pin_out[1] = !irq_pend;
      s_d.pin_oe_n[1] = 1'b0;
    end
    s_d.bus_en = 1'b1;
    s_d.afc_en = s_d.props[rcpe_pkg::IDX_REFCLK] != 16'h0000;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_q <= rst_state();
    end else begin
      s_q <= s_d;
    end
  end

  assign status_o = s_q.status;
  assign rsp_byte_o = s_q.rsp_byte;
  assign bus_en_o = s_q.bus_en;
  assign powered_o = s_q.pwr;
  assign mode_tx_o = s_q.mode_tx;
  assign afc_en_o = s_q.afc_en;
  assign rds_pop_o = s_q.rds_pop;
  assign dsp_cmd_o = s_q.dsp;
  assign prop_map_o = s_q.props;
  assign general_output_one_o = s_q.pin_out[0];
  assign general_output_one_oe_n_o = s_q.pin_oe_n[0];
  assign general_output_two_irq_o = s_q.pin_out[1];
  assign general_output_two_irq_oe_n_o = s_q.pin_oe_n[1];
  assign general_output_three_bitclk_o = s_q.pin_out[2];
  assign general_output_three_bitclk_oe_n_o = s_q.pin_oe_n[2];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_accept;
    s_q.fsm == rcpe_pkg::ST_IDLE && cmd_go_i && status_o[7] && s_q.nbytes != 4'h0;
  endsequence

  sequence s_done_op(logic [7:0] code);
    exec_done && s_q.pwr && op == code;
  endsequence

  property p_cts_drop;
    s_accept |=> !status_o[7];
  endproperty
  a_cts_drop: assert property (p_cts_drop) else $error("ready not cleared");

  property p_cts_return;
    s_accept |=> (!status_o[7])[*1] ##(EXEC_A - 1) status_o[7];
  endproperty
  a_cts_return: assert property (p_cts_return) else $error("ready late");

  property p_out_of_reset;
    $past(sys_rst_i) |-> !powered_o && !bus_en_o && afc_en_o && general_output_one_oe_n_o
      && status_o == 8'h80 && prop_map_o[rcpe_pkg::IDX_REFCLK] == 16'h8000;
  endproperty
  a_out_of_reset: assert property (p_out_of_reset) else $error("bad post-reset state");

  property p_off_quiet;
    !powered_o |-> !dsp_cmd_o.valid;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("processing while off");

  property p_irq_pin;
    s_q.irq_en && |(status_o[3:0] & prop_map_o[0][3:0]) |-> !general_output_two_irq_o
      && !general_output_two_irq_oe_n_o;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin wrong");

  property p_pin_sel;
    s_done_op(rcpe_pkg::CMD_PIN_DRIVE_SEL) ##0 !s_q.irq_en
      |=> general_output_one_oe_n_o == !$past(s_q.cmd[1][1]);
  endproperty
  a_pin_sel: assert property (p_pin_sel) else $error("pin drive select lost");

  property p_status_first;
    s_q.rsp_idx == 4'h0 |-> rsp_byte_o == status_o;
  endproperty
  a_status_first: assert property (p_status_first) else $error("status byte missing");

  property p_refclk_bad;
    s_done_op(rcpe_pkg::CMD_PROP_WRITE) ##0 int'(hit_idx[5:0]) == rcpe_pkg::IDX_REFCLK
      && hit_idx[6] && pval > rcpe_pkg::REFCLK_MAX
      |=> status_o[6] && $stable(prop_map_o[rcpe_pkg::IDX_REFCLK]);
  endproperty
  a_refclk_bad: assert property (p_refclk_bad) else $error("bad clock value kept");

  property p_prop_readback;
    s_done_op(rcpe_pkg::CMD_PROP_READ) ##0 hit_idx[6]
      |=> s_q.rsp[3] == $past(s_q.props[hit_idx[5:0]][7:0]) && !status_o[6];
  endproperty
  a_prop_readback: assert property (p_prop_readback) else $error("readback wrong");

  property p_byte_store;
    s_q.fsm == rcpe_pkg::ST_IDLE && cmd_wr_i && status_o[7] && s_q.nbytes < 4'h8
      |=> s_q.cmd[$past(s_q.nbytes[2:0])] == $past(cmd_byte_i)
      && s_q.nbytes == $past(s_q.nbytes) + 4'h1;
  endproperty
  a_byte_store: assert property (p_byte_store) else $error("command byte lost");

  property p_power_down;
    s_done_op(rcpe_pkg::CMD_POWER_DOWN) |=> !powered_o && status_o[7];
  endproperty
  a_power_down: assert property (p_power_down) else $error("power down ignored");

  property p_off_refuses;
    exec_done && !s_q.pwr && op != rcpe_pkg::CMD_POWER_UP |=> status_o[6] && !powered_o;
  endproperty
  a_off_refuses: assert property (p_off_refuses) else $error("command run while off");

  property p_tune_event;
    powered_o && tune_done_i |=> status_o[rcpe_pkg::ST_STC];
  endproperty
  a_tune_event: assert property (p_tune_event) else $error("tune event lost");

  property p_wrong_mode;
    s_done_op(rcpe_pkg::CMD_TX_FREQ) ##0 !s_q.mode_tx |=> status_o[rcpe_pkg::ST_ERR];
  endproperty
  a_wrong_mode: assert property (p_wrong_mode) else $error("wrong mode accepted");

endmodule

/* tb/rcpe_host.sv */
// host model that issues commands and collects answers
`timescale 1ns/1ns
module rcpe_host (
  input wire logic clk_i,
  input wire logic [7:0] status_i,
  input wire logic [7:0] rsp_byte_i,
  input wire rcpe_pkg::rcpe_dsp_cmd_t dsp_cmd_i,
  input wire logic rds_pop_i,
  output logic cmd_wr_o,
  output logic [7:0] cmd_byte_o,
  output logic cmd_go_o,
  output logic rsp_rd_o
);
  int lat;
  logic low_after_go;
  logic pop;
  logic [7:0] rsp [4];
  rcpe_pkg::rcpe_dsp_cmd_t dsp;

  initial begin
    cmd_wr_o = 1'b0;
    cmd_byte_o = 8'h00;
    cmd_go_o = 1'b0;
    rsp_rd_o = 1'b0;
  end

  // bytes in b from the top, opcode first; n bytes sent
  task automatic run(input logic [63:0] b, input int n);
    int i;
    i = 0;
    while (status_i[7] !== 1'b1 && i < 1000) begin
      @(posedge clk_i);
      #1;
      i++;
    end
    for (i = 0; i < n && i < 8; i++) begin
      @(posedge clk_i);
      cmd_wr_o <= 1'b1;
      cmd_byte_o <= b[63-8*i -: 8];
    end
    @(posedge clk_i);
    cmd_wr_o <= 1'b0;
    // released data line must not keep the last byte
    cmd_byte_o <= ~cmd_byte_o;
    cmd_go_o <= 1'b1;
    @(posedge clk_i);
    cmd_go_o <= 1'b0;
    #1;
    low_after_go = ~status_i[7];
    lat = 0;
    while (status_i[7] !== 1'b1 && lat < 1000) begin
      @(posedge clk_i);
      #1;
      lat++;
    end
    dsp = dsp_cmd_i;
    pop = rds_pop_i;
    rsp[0] = rsp_byte_i;
    for (i = 1; i < 4; i++) begin
      @(posedge clk_i);
      rsp_rd_o <= 1'b1;
      @(posedge clk_i);
      rsp_rd_o <= 1'b0;
      #1;
      rsp[i] = rsp_byte_i;
    end
  endtask
endmodule

/* tb/radio_command_property_engine_tb_top.sv */
// testbench of the command and property engine
`timescale 1ns/1ns
module radio_command_property_engine_tb_top;
  localparam int EXEC = 4;
  localparam logic [15:0] EXP_RST [34] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0001,
    16'h0003, 16'h1AA9, 16'h02A3, 16'h00C8, 16'h327C, 16'h0000, 16'h0000, 16'h4A38,
    16'h0002, 16'hFFD8, 16'h0000, 16'h0004, 16'h000F, 16'h0066, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h40A7, 16'h0003, 16'h1008, 16'h0003,
    16'h0001, 16'hE0E0, 16'h0000};
  logic clk = 1'b0;
  logic sys_rst = 1'b0;
  logic tune_done = 1'b0;
  logic asq_evt = 1'b0;
  logic rds_evt = 1'b0;
  logic rsq_evt = 1'b0;
  logic cmd_wr, cmd_go, rsp_rd, bus_en, powered, mode_tx, afc_en, rds_pop;
  logic p1, p1_oe_n, p2, p2_oe_n, p3, p3_oe_n;
  logic [7:0] cmd_byte, status, rsp_byte;
  rcpe_pkg::rcpe_dsp_cmd_t dsp_cmd;
  logic [rcpe_pkg::PROP_N-1:0][15:0] prop_map;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  rcpe_engine #(.EXEC_CYCLES(EXEC)) i_rcpe_engine (.clk_i(clk), .sys_rst_i(sys_rst),
    .cmd_wr_i(cmd_wr), .cmd_byte_i(cmd_byte), .cmd_go_i(cmd_go), .rsp_rd_i(rsp_rd),
    .tune_done_i(tune_done), .asq_evt_i(asq_evt), .rds_evt_i(rds_evt), .rsq_evt_i(rsq_evt),
    .status_o(status), .rsp_byte_o(rsp_byte), .bus_en_o(bus_en), .powered_o(powered),
    .mode_tx_o(mode_tx), .afc_en_o(afc_en), .rds_pop_o(rds_pop), .dsp_cmd_o(dsp_cmd),
    .prop_map_o(prop_map), .general_output_one_o(p1), .general_output_one_oe_n_o(p1_oe_n),
    .general_output_two_irq_o(p2), .general_output_two_irq_oe_n_o(p2_oe_n),
    .general_output_three_bitclk_o(p3), .general_output_three_bitclk_oe_n_o(p3_oe_n));

  rcpe_host i_rcpe_host (.clk_i(clk), .status_i(status), .rsp_byte_i(rsp_byte),
    .dsp_cmd_i(dsp_cmd), .rds_pop_i(rds_pop), .cmd_wr_o(cmd_wr), .cmd_byte_o(cmd_byte),
    .cmd_go_o(cmd_go), .rsp_rd_o(rsp_rd));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cmd(input logic [63:0] b, input int n);
    i_rcpe_host.run(b, n);
    check(i_rcpe_host.low_after_go, 1'b1);
    check(i_rcpe_host.lat, EXEC);
  endtask

  // m is {quality, data, audio, tune} event pulses
  task automatic ev(input logic [3:0] m);
    @(posedge clk);
    {rsq_evt, rds_evt, asq_evt, tune_done} <= m;
    @(posedge clk);
    {rsq_evt, rds_evt, asq_evt, tune_done} <= 4'h0;
    #1;
  endtask

  task automatic s_reset();
    int i;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    check(bus_en, 1'b0);
    @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    check(status, 8'h80);
    check({powered, bus_en, afc_en}, 3'h3);
    check({p1_oe_n, p2_oe_n, p3_oe_n}, 3'h7);
    for (i = 0; i < 34; i++) check(prop_map[i], EXP_RST[i]);
  endtask

  task automatic s_down();
    cmd(64'h1200210112340000, 6);
    check(status, 8'hC0);
    check(i_rcpe_host.low_after_go, 1'b1);
    check(i_rcpe_host.lat, EXEC);
    check(prop_map[8], 16'h1AA9);
    cmd(64'h0105000000000000, 2);
    check({status, powered}, 9'h180);
    cmd(64'h0102000000000000, 2);
    check({status, powered, mode_tx}, 10'h203);
    check({i_rcpe_host.dsp.valid, i_rcpe_host.dsp.opcode}, 9'h001);
    check(i_rcpe_host.dsp.args[0], 8'h02);
  endtask

  task automatic s_props();
    int i;
    logic [15:0] v [5] = '{16'd31129, 16'd0, 16'd34406, 16'd34407, 16'd31130};
    logic [15:0] e [5] = '{16'd32768, 16'd0, 16'd34406, 16'd34406, 16'd31130};
    cmd(64'h1200210112340000, 6);
    check(prop_map[8], 16'h1234);
    cmd(64'h1300210100000000, 4);
    check({i_rcpe_host.rsp[1], i_rcpe_host.rsp[2], i_rcpe_host.rsp[3]}, 24'h001234);
    cmd(64'h1300999900000000, 4);
    check(status, 8'hC0);
    for (i = 0; i < 5; i++) begin
      cmd({16'h1200, 16'h0201, v[i], 16'h0000}, 6);
      check(status, (e[i] === v[i]) ? 8'h80 : 8'hC0);
      check({prop_map[5], afc_en}, {e[i], e[i] != 16'h0000});
    end
    // four blocks wanted, so one more is written
    cmd(64'h12002C0700050000, 6);
    check(prop_map[33], 16'h0005);
  endtask

  task automatic s_rev();
    cmd(64'h1000000000000000, 1);
    check({i_rcpe_host.rsp[1], i_rcpe_host.rsp[2], i_rcpe_host.rsp[3]},
      {rcpe_pkg::REV_PART, rcpe_pkg::REV_MAJOR, rcpe_pkg::REV_MINOR});
  endtask

  task automatic s_pins();
    cmd(64'h800A000000000000, 2);
    check({p3_oe_n, p2_oe_n, p1_oe_n}, 3'b010);
    cmd(64'h8108000000000000, 2);
    check({p3, p1}, 2'b10);
    cmd(64'h800E000000000000, 2);
    cmd(64'h8104000000000000, 2);
    check({p3_oe_n, p2_oe_n, p1_oe_n, p3, p2, p1}, 6'b000010);
  endtask

  task automatic s_tx();
    int i;
    logic [7:0] ops [9] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h15, 8'h16};
    for (i = 0; i < 9; i++) begin
      cmd({ops[i], 56'h0}, 1);
      check(status, 8'h80);
      check({i_rcpe_host.dsp.valid, i_rcpe_host.dsp.opcode}, {i < 7, ops[i]});
    end
    cmd(64'h2000000000000000, 1);
    check(status, 8'hC0);
    cmd(64'h7F00000000000000, 1);
    check(status, 8'hC0);
    ev(4'h8);
    check(status, 8'hC0);
    ev(4'h2);
    check(status, 8'hC2);
    cmd(64'h1400000000000000, 1);
    check(status, 8'h82);
    cmd(64'h3401000000000000, 2);
    check({status, i_rcpe_host.rsp[1][0]}, 9'h101);
  endtask

  task automatic s_rx();
    int i;
    logic [7:0] ops [5] = '{8'h20, 8'h21, 8'h23, 8'h27, 8'h28};
    cmd(64'h1100000000000000, 1);
    check(powered, 1'b0);
    cmd(64'h0140000000000000, 2);
    check({powered, mode_tx, prop_map[8]}, 18'h21234);
    cmd(64'h1200000100010000, 6);
    check({p2_oe_n, p2}, 2'b01);
    for (i = 0; i < 5; i++) begin
      cmd({ops[i], 56'h0}, 1);
      check(status, 8'h80);
    end
    cmd(64'h3000000000000000, 1);
    check(status, 8'hC0);
    ev(4'h1);
    check({status[0], p2_oe_n, p2}, 3'b100);
    cmd(64'h2201000000000000, 2);
    check({status, p2}, 9'h101);
    ev(4'h4);
    cmd(64'h2401000000000000, 2);
    check({status, i_rcpe_host.pop}, 9'h101);
  endtask

  initial begin
    s_reset();
    s_down();
    s_props();
    s_rev();
    s_pins();
    s_tx();
    s_rx();
    s_reset();
    report_and_stop();
  end
endmodule
